// >>> rtl/iglc_top.v
`timescale 1ns/1ps
`default_nettype none

`include "iglc_regs.vh"

module iglc_top #(
  parameter RE_TIMEOUT_CYCLES = `IGLC_RE_TIMEOUT_NS / `IGLC_CLK_PERIOD_NS
) (
  input  wire        CLK_SYS,
  input  wire        RSTN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire        SAMPLE_STB,
  input  wire [7:0]  LEVEL_CH0,
  input  wire [7:0]  LEVEL_CH1,
  input  wire [7:0]  LEVEL_CH2,
  input  wire [7:0]  LEVEL_CH3,
  output wire [7:0]  DIG_GAIN_CH0,
  output wire [7:0]  DIG_GAIN_CH1,
  output wire [7:0]  DIG_GAIN_CH2,
  output wire [7:0]  DIG_GAIN_CH3,
  output wire [3:0]  ANA_GAIN_CH0,
  output wire [3:0]  ANA_GAIN_CH1,
  output wire [3:0]  ANA_GAIN_CH2,
  output wire [3:0]  ANA_GAIN_CH3,
  output wire        CALIB_ACTIVE,
  output wire        CALIB_OFFSET_EN,
  output wire        HOST_INTERRUPT_N
);

  // ****************************************************************
  // register file
  // ****************************************************************
  reg  [31:0] level_ctl_enable_reg_ff;
  reg  [31:0] level_ctl_rate_reg_ff;
  reg  [31:0] level_ctl_hold_reg_ff;
  reg  [31:0] thresh_reg_ff;
  reg  [31:0] limits_reg_ff;
  reg  [31:0] manual_dig_ff;
  reg  [31:0] manual_ana_ff;
  reg  [31:0] range_ext_reg_ff;
  reg  [31:0] lvl_det_reg_ff;
  reg         cal_auto_ff;
  reg         cal_ofs_en_ff;
  reg  [10:0] cal_cnt_ff;
  reg  [10:0] nxt_cal_cnt;
  reg         det_flag_ff;
  reg         nxt_det_flag;
  reg         irq_n_ff;
  reg  [31:0] dig_gain_ff;
  reg  [15:0] ana_gain_ff;
  reg  [31:0] nxt_dig_gain;
  reg  [15:0] nxt_ana_gain;
  reg  [11:0] re_att_ff;
  reg  [11:0] nxt_re_att;
  reg  [23:0] re_tmo_ff;
  reg  [23:0] nxt_re_tmo;
  reg         addr_ok;
  reg  [31:0] rd_mux;

  wire        wr_en;
  wire        rd_en;
  wire [31:0] levels;
  wire [35:0] chan_gain;
  wire [3:0]  alc_en;
  wire        hybrid;
  wire [3:0]  re_en;
  wire [7:0]  re_trig;
  wire [2:0]  re_att_max;
  wire [7:0]  ac_thr;
  wire [7:0]  det_thr;
  wire        cal_done;
  wire [3:0]  det_hit;

  localparam [31:0] CAL_LAST_W    = `IGLC_CALIB_CYCLES - 1;
  localparam [31:0] RE_TMO_LAST_W = RE_TIMEOUT_CYCLES - 1;
  localparam [10:0] CAL_LAST      = CAL_LAST_W[10:0];
  localparam [23:0] RE_TMO_LAST   = RE_TMO_LAST_W[23:0];

  assign levels  = {LEVEL_CH3, LEVEL_CH2, LEVEL_CH1, LEVEL_CH0};
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && PENABLE && !PWRITE;
  // zero wait states; unmapped offsets answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // range extension wins nothing: level control has priority
  assign alc_en     = level_ctl_enable_reg_ff[3:0];
  assign hybrid     = level_ctl_enable_reg_ff[`IGLC_BIT_HYBRID];
  assign re_en      = range_ext_reg_ff[3:0] & ~alc_en;
  // trigger -90 dB + 6 dB per step: 8 level codes per step
  assign re_trig    = `IGLC_LVL_FULL - `IGLC_RE_FLOOR
                      + {1'b0, range_ext_reg_ff[7:4], 3'b000};
  // 0..36 dB in 6 dB steps, larger codes saturate
  assign re_att_max = (range_ext_reg_ff[10:8] > `IGLC_RE_ATT_LIMIT) ?
                      `IGLC_RE_ATT_LIMIT : range_ext_reg_ff[10:8];
  // anti-clip window below full scale
  assign ac_thr     = `IGLC_LVL_FULL - {5'h00, level_ctl_enable_reg_ff[10:8]}
                      - 8'h01;
  // 0 = full scale, 56 = 1/128 full scale
  assign det_thr    = `IGLC_LVL_FULL - ((lvl_det_reg_ff[5:0] >
                      `IGLC_DET_MAX_ATT) ? {2'b00, `IGLC_DET_MAX_ATT} :
                      {2'b00, lvl_det_reg_ff[5:0]});
  assign cal_done   = cal_auto_ff && (cal_cnt_ff == CAL_LAST);

  assign DIG_GAIN_CH0     = dig_gain_ff[7:0];
  assign DIG_GAIN_CH1     = dig_gain_ff[15:8];
  assign DIG_GAIN_CH2     = dig_gain_ff[23:16];
  assign DIG_GAIN_CH3     = dig_gain_ff[31:24];
  assign ANA_GAIN_CH0     = ana_gain_ff[3:0];
  assign ANA_GAIN_CH1     = ana_gain_ff[7:4];
  assign ANA_GAIN_CH2     = ana_gain_ff[11:8];
  assign ANA_GAIN_CH3     = ana_gain_ff[15:12];
  assign CALIB_ACTIVE     = cal_auto_ff;
  assign CALIB_OFFSET_EN  = cal_ofs_en_ff;
  assign HOST_INTERRUPT_N = irq_n_ff;

  // ****************************************************************
  // gain helpers
  // ****************************************************************
  function [8:0] lim_total;
    input       hyb;
    input       upper;
    input [31:0] lims;
    begin
      if (hyb && upper)
        lim_total = {2'b00, lims[23:20], 3'b000} + {1'b0, lims[15:8]};
      else if (hyb)
        lim_total = {2'b00, lims[19:16], 3'b000} + {1'b0, lims[7:0]};
      else if (upper)
        lim_total = {1'b0, lims[15:8]};
      else
        lim_total = {1'b0, lims[7:0]};
    end
  endfunction

  // analog part of a hybrid total gain, kept in analog limits
  function [3:0] ana_part;
    input [8:0]  tot;
    input [31:0] lims;
    reg   [8:0]  room;
    begin
      room = 9'h000;
      if (tot > {1'b0, lims[15:8]})
        room = tot - {1'b0, lims[15:8]} + 9'h007;
      if (room[8:3] < {2'b00, lims[19:16]})
        ana_part = lims[19:16];
      else if (room[8:3] > {2'b00, lims[23:20]})
        ana_part = lims[23:20];
      else
        ana_part = room[6:3];
    end
  endfunction

  // digital gain minus an analog boost, floored at zero
  function [7:0] dig_less;
    input [8:0] tot;
    input [3:0] ana;
    reg   [8:0] sub;
    reg   [8:0] dif;
    begin
      sub = {2'b00, ana, 3'b000};
      dif = tot - sub;
      // the limits keep the digital part below nine bits
      dig_less = (tot > sub) ? dif[7:0] : 8'h00;
    end
  endfunction

  // ****************************************************************
  // per-channel level control engines
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_chan
      wire [8:0] init_g;
      assign init_g = hybrid ?
        {2'b00, manual_ana_ff[g*4+3:g*4], 3'b000}
        + {1'b0, manual_dig_ff[g*8+7:g*8]} :
        {1'b0, manual_dig_ff[g*8+7:g*8]};
      assign det_hit[g] = levels[g*8+7:g*8] > det_thr;
      iglc_chan u_chan (
        .clk          (CLK_SYS),
        .rstn         (RSTN),
        .sample_stb   (SAMPLE_STB),
        .enable       (alc_en[g]),
        .level        (levels[g*8+7:g*8]),
        .thr_min      (thresh_reg_ff[7:0]),
        .thr_max      (thresh_reg_ff[15:8]),
        .noise_thr    (thresh_reg_ff[23:16]),
        .attack_rate  (level_ctl_rate_reg_ff[3:0]),
        .release_rate (level_ctl_rate_reg_ff[7:4]),
        .hold_len     (level_ctl_hold_reg_ff[7:0]),
        .anticlip_en  (level_ctl_enable_reg_ff[`IGLC_BIT_AC_EN]),
        .anticlip_thr (ac_thr),
        .lim_lo       (lim_total(hybrid, 1'b0, limits_reg_ff)),
        .lim_hi       (lim_total(hybrid, 1'b1, limits_reg_ff)),
        .init_gain    (init_g),
        .total_gain   (chan_gain[g*9+8:g*9])
      );
    end
  endgenerate

  // ****************************************************************
  // range extension and gain outputs
  // ****************************************************************
  integer i;
  always @* begin
    nxt_re_att   = re_att_ff;
    nxt_re_tmo   = re_tmo_ff;
    nxt_dig_gain = manual_dig_ff;
    nxt_ana_gain = manual_ana_ff[15:0];
    for (i = 0; i < 4; i = i + 1) begin
      if (!re_en[i]) begin
        nxt_re_att[i*3 +: 3] = 3'h0;
      end else if (SAMPLE_STB) begin
        if (range_ext_reg_ff[`IGLC_BIT_RE_AC_EN]
            && levels[i*8 +: 8] >= ac_thr) begin
          nxt_re_att[i*3 +: 3] = 3'h0;
        end else if (levels[i*8 +: 8] > re_trig) begin
          if (re_att_ff[i*3 +: 3] != 3'h0)
            nxt_re_att[i*3 +: 3] = re_att_ff[i*3 +: 3] - 3'h1;
        end else if (re_att_ff[i*3 +: 3] < re_att_max) begin
          if (!range_ext_reg_ff[`IGLC_BIT_RE_TMO_EN]
              || re_tmo_ff == RE_TMO_LAST)
            nxt_re_att[i*3 +: 3] = re_att_ff[i*3 +: 3] + 3'h1;
        end
      end
      if (re_att_ff[i*3 +: 3] > re_att_max)
        nxt_re_att[i*3 +: 3] = re_att_max;
      if (alc_en[i]) begin
        // in hybrid, manual fields are read only as starting point; otherwise the analog output stays manual
        if (hybrid) begin
          nxt_ana_gain[i*4 +: 4] = ana_part(chan_gain[i*9 +: 9],
                                            limits_reg_ff);
          nxt_dig_gain[i*8 +: 8] = dig_less(chan_gain[i*9 +: 9],
                                   ana_part(chan_gain[i*9 +: 9],
                                            limits_reg_ff));
        end else begin
          nxt_dig_gain[i*8 +: 8] = chan_gain[i*9 +: 8];
        end
      end else if (re_en[i]) begin
        // equal and opposite: +1 analog code is -8 digital codes
        nxt_ana_gain[i*4 +: 4] = manual_ana_ff[i*4 +: 4]
                                 + {1'b0, re_att_ff[i*3 +: 3]};
        nxt_dig_gain[i*8 +: 8] = dig_less({1'b0, manual_dig_ff[i*8 +: 8]},
                                 {1'b0, re_att_ff[i*3 +: 3]});
      end
    end
    // timeout runs while any channel has range extension enabled
    if (re_en == 4'h0 || re_tmo_ff == RE_TMO_LAST)
      nxt_re_tmo = 24'h000000;
    else
      nxt_re_tmo = re_tmo_ff + 24'h000001;
  end

  // ****************************************************************
  // calibration and level detect
  // ****************************************************************
  always @* begin
    nxt_cal_cnt = cal_auto_ff ? cal_cnt_ff + 11'h001 : 11'h000;
    if (cal_done)
      nxt_cal_cnt = 11'h000;
    // a new event beats a clear in the same cycle
    nxt_det_flag = det_flag_ff;
    if (wr_en && PADDR == `IGLC_OFS_LVL_DET
        && PWDATA[`IGLC_BIT_DET_FLAG])
      nxt_det_flag = 1'b0;
    if (lvl_det_reg_ff[`IGLC_BIT_DET_EN] && det_hit != 4'h0)
      nxt_det_flag = 1'b1;
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cal_cnt_ff  <= 11'h000;
      det_flag_ff <= 1'b0;
      irq_n_ff    <= 1'b1;
      re_att_ff   <= 12'h000;
      re_tmo_ff   <= 24'h000000;
      dig_gain_ff <= `IGLC_RST_MAN_DIG;
      ana_gain_ff <= 16'h0000;
    end else begin
      cal_cnt_ff  <= nxt_cal_cnt;
      det_flag_ff <= nxt_det_flag;
      irq_n_ff    <= !nxt_det_flag;
      re_att_ff   <= nxt_re_att;
      re_tmo_ff   <= nxt_re_tmo;
      dig_gain_ff <= nxt_dig_gain;
      ana_gain_ff <= nxt_ana_gain;
    end
  end

  // ****************************************************************
  // apb write side
  // ****************************************************************
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      level_ctl_enable_reg_ff <= `IGLC_RST_LC_ENABLE;
      level_ctl_rate_reg_ff   <= `IGLC_RST_LC_RATE;
      level_ctl_hold_reg_ff   <= `IGLC_RST_LC_HOLD;
      thresh_reg_ff           <= `IGLC_RST_LC_THRESH;
      limits_reg_ff           <= `IGLC_RST_LC_LIMITS;
      manual_dig_ff           <= `IGLC_RST_MAN_DIG;
      manual_ana_ff           <= `IGLC_RST_MAN_ANA;
      range_ext_reg_ff        <= `IGLC_RST_RANGE_EXT;
      lvl_det_reg_ff          <= `IGLC_RST_LVL_DET;
      cal_auto_ff             <= 1'b0;
      cal_ofs_en_ff           <= 1'b0;
    end else begin
      // finishing clears the bit; a write of 1 in that cycle restarts
      if (cal_done)
        cal_auto_ff <= 1'b0;
      if (wr_en) begin
        case (PADDR)
          `IGLC_OFS_LC_ENABLE: level_ctl_enable_reg_ff <= PWDATA;
          `IGLC_OFS_LC_RATE:   level_ctl_rate_reg_ff   <= PWDATA;
          `IGLC_OFS_LC_HOLD:   level_ctl_hold_reg_ff   <= PWDATA;
          `IGLC_OFS_LC_THRESH: thresh_reg_ff           <= PWDATA;
          `IGLC_OFS_LC_LIMITS: limits_reg_ff           <= PWDATA;
          `IGLC_OFS_MAN_DIG:   manual_dig_ff           <= PWDATA;
          `IGLC_OFS_MAN_ANA:   manual_ana_ff           <= PWDATA;
          `IGLC_OFS_RANGE_EXT: range_ext_reg_ff        <= PWDATA;
          `IGLC_OFS_LVL_DET:   lvl_det_reg_ff          <= PWDATA;
          `IGLC_OFS_CALIB: begin
            if (PWDATA[`IGLC_BIT_CAL_AUTO])
              cal_auto_ff <= 1'b1;
            cal_ofs_en_ff <= PWDATA[`IGLC_BIT_CAL_OFS_EN];
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************************************
  // apb read side
  // ****************************************************************
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (PADDR)
      `IGLC_OFS_LC_ENABLE: rd_mux = level_ctl_enable_reg_ff;
      `IGLC_OFS_LC_RATE:   rd_mux = level_ctl_rate_reg_ff;
      `IGLC_OFS_LC_HOLD:   rd_mux = level_ctl_hold_reg_ff;
      `IGLC_OFS_LC_THRESH: rd_mux = thresh_reg_ff;
      `IGLC_OFS_LC_LIMITS: rd_mux = limits_reg_ff;
      `IGLC_OFS_MAN_DIG:   rd_mux = manual_dig_ff;
      `IGLC_OFS_MAN_ANA:   rd_mux = manual_ana_ff;
      `IGLC_OFS_RANGE_EXT: rd_mux = range_ext_reg_ff;
      `IGLC_OFS_CALIB: begin
        rd_mux[`IGLC_BIT_CAL_AUTO]   = cal_auto_ff;
        rd_mux[`IGLC_BIT_CAL_OFS_EN] = cal_ofs_en_ff;
        rd_mux[`IGLC_BIT_CAL_BUSY]   = cal_auto_ff;
      end
      `IGLC_OFS_LVL_DET: begin
        rd_mux = lvl_det_reg_ff & 32'h0000_013F;
        rd_mux[`IGLC_BIT_DET_FLAG] = det_flag_ff;
      end
      `IGLC_OFS_GAIN_STAT: rd_mux = dig_gain_ff;
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN)
      PRDATA <= 32'h0000_0000;
    else if (PSEL && !PENABLE && !PWRITE)
      PRDATA <= rd_mux;
  end

endmodule

`default_nettype wire

// >>> rtl/iglc_regs.vh
`ifndef IGLC_REGS_VH
`define IGLC_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define IGLC_OFS_LC_ENABLE   8'h00
`define IGLC_OFS_LC_RATE     8'h04
`define IGLC_OFS_LC_HOLD     8'h08
`define IGLC_OFS_LC_THRESH   8'h0C
`define IGLC_OFS_LC_LIMITS   8'h10
`define IGLC_OFS_MAN_DIG     8'h14
`define IGLC_OFS_MAN_ANA     8'h18
`define IGLC_OFS_RANGE_EXT   8'h1C
`define IGLC_OFS_CALIB       8'h20
`define IGLC_OFS_LVL_DET     8'h24
`define IGLC_OFS_GAIN_STAT   8'h28

// ****************************************************************
// field positions
// ****************************************************************
`define IGLC_BIT_HYBRID      4
`define IGLC_BIT_AC_EN       5
`define IGLC_BIT_RE_TMO_EN   11
`define IGLC_BIT_RE_AC_EN    12
`define IGLC_BIT_CAL_AUTO    0
`define IGLC_BIT_CAL_OFS_EN  1
`define IGLC_BIT_CAL_BUSY    2
`define IGLC_BIT_DET_EN      8
`define IGLC_BIT_DET_FLAG    16

// ****************************************************************
// reset values
// ****************************************************************
`define IGLC_RST_LC_ENABLE   32'h0000_0000
`define IGLC_RST_LC_RATE     32'h0000_00F1
`define IGLC_RST_LC_HOLD     32'h0000_0010
`define IGLC_RST_LC_THRESH   32'h0020_E0C0
`define IGLC_RST_LC_LIMITS   32'h0000_F000
`define IGLC_RST_MAN_DIG     32'h8080_8080
`define IGLC_RST_MAN_ANA     32'h0000_0000
`define IGLC_RST_RANGE_EXT   32'h0000_0000
`define IGLC_RST_LVL_DET     32'h0000_0000

// ****************************************************************
// level codes and timing (level unit 0.75 dB, 255 = full scale)
// ****************************************************************
`define IGLC_LVL_FULL        8'hFF
`define IGLC_ANA_UNIT        9'h008
`define IGLC_AC_STEP         9'h004
`define IGLC_RE_FLOOR        8'h78
`define IGLC_DET_MAX_ATT     6'h38
`define IGLC_RE_ATT_LIMIT    3'h6
`define IGLC_RE_TIMEOUT_NS   100000000
`define IGLC_CLK_PERIOD_NS   8
`define IGLC_CALIB_CYCLES    1024

`endif

// >>> rtl/iglc_chan.v
`timescale 1ns/1ps
`default_nettype none

`include "iglc_regs.vh"

module iglc_chan (
  input  wire       clk,
  input  wire       rstn,
  input  wire       sample_stb,
  input  wire       enable,
  input  wire [7:0] level,
  input  wire [7:0] thr_min,
  input  wire [7:0] thr_max,
  input  wire [7:0] noise_thr,
  input  wire [3:0] attack_rate,
  input  wire [3:0] release_rate,
  input  wire [7:0] hold_len,
  input  wire       anticlip_en,
  input  wire [7:0] anticlip_thr,
  input  wire [8:0] lim_lo,
  input  wire [8:0] lim_hi,
  input  wire [8:0] init_gain,
  output wire [8:0] total_gain
);

  reg [8:0] gain_ff;
  reg [8:0] nxt_gain;
  reg [3:0] rate_cnt_ff;
  reg [3:0] nxt_rate_cnt;
  reg [7:0] hold_ff;
  reg [7:0] nxt_hold;
  reg       clip;
  reg       loud;
  reg       quiet;
  reg       gated;

  function [8:0] clamp9;
    input [8:0] v;
    input [8:0] lo;
    input [8:0] hi;
    begin
      if (v < lo)
        clamp9 = lo;
      else if (v > hi)
        clamp9 = hi;
      else
        clamp9 = v;
    end
  endfunction

  assign total_gain = gain_ff;

  always @* begin
    nxt_gain     = clamp9(gain_ff, lim_lo, lim_hi);
    nxt_rate_cnt = rate_cnt_ff;
    nxt_hold     = hold_ff;
    clip  = anticlip_en && (level >= anticlip_thr);
    loud  = level > thr_max;
    quiet = level < thr_min;
    gated = level < noise_thr;
    if (!enable) begin
      nxt_gain     = init_gain;
      nxt_rate_cnt = 4'h0;
      nxt_hold     = 8'h00;
    end else if (sample_stb) begin
      if (clip) begin
        // fast attack near full scale
        nxt_gain     = (nxt_gain > lim_lo + `IGLC_AC_STEP) ?
                       nxt_gain - `IGLC_AC_STEP : lim_lo;
        nxt_rate_cnt = 4'h0;
        nxt_hold     = hold_len;
      end else if (loud) begin
        if (rate_cnt_ff >= attack_rate) begin
          if (nxt_gain > lim_lo)
            nxt_gain = nxt_gain - 9'h001;
          nxt_rate_cnt = 4'h0;
        end else begin
          nxt_rate_cnt = rate_cnt_ff + 4'h1;
        end
        nxt_hold = hold_len;
      end else if (hold_ff != 8'h00) begin
        nxt_hold     = hold_ff - 8'h01;
        nxt_rate_cnt = 4'h0;
      end else if (quiet && !gated) begin
        if (rate_cnt_ff >= release_rate) begin
          if (nxt_gain < lim_hi)
            nxt_gain = nxt_gain + 9'h001;
          nxt_rate_cnt = 4'h0;
        end else begin
          nxt_rate_cnt = rate_cnt_ff + 4'h1;
        end
      end else begin
        // in band or noise gated: gain held
        nxt_rate_cnt = 4'h0;
      end
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gain_ff     <= 9'h000;
      rate_cnt_ff <= 4'h0;
      hold_ff     <= 8'h00;
    end else begin
      gain_ff     <= nxt_gain;
      rate_cnt_ff <= nxt_rate_cnt;
      hold_ff     <= nxt_hold;
    end
  end

endmodule

`default_nettype wire

// >>> test/iglc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module iglc_chk (
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PSLVERR,
  input wire logic        SAMPLE_STB,
  input wire logic [7:0]  LEVEL_CH0,
  input wire logic [7:0]  DIG_GAIN_CH0,
  input wire logic [7:0]  DIG_GAIN_CH1,
  input wire logic [3:0]  ANA_GAIN_CH1,
  input wire logic        CALIB_ACTIVE,
  input wire logic        CALIB_OFFSET_EN,
  input wire logic        HOST_INTERRUPT_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  wire logic   wr = PSEL && PENABLE && PWRITE;
  wire logic   stb0 = SAMPLE_STB;
  logic [10:0] cal_cnt_ff;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN)
      cal_cnt_ff <= 11'h000;
    else
      cal_cnt_ff <= CALIB_ACTIVE ? cal_cnt_ff + 11'h001 : 11'h000;
  end
  AST_SLVERR:
    assert property (PSEL && PENABLE && PADDR > 8'h28 |-> PSLVERR)
      else $error("unmapped access without error");
  AST_CAL_START:
    assert property (wr && PADDR == 8'h20 && PWDATA[0] |=> CALIB_ACTIVE)
      else $error("calibration did not start");
  AST_CAL_LEN:
    assert property (CALIB_ACTIVE |-> cal_cnt_ff < 11'h406)
      else $error("calibration never ends");
  AST_CAL_END:
    assert property ($fell(CALIB_ACTIVE) |-> $past(cal_cnt_ff) > 11'h3F8)
      else $error("calibration ended early");
  AST_OFS:
    assert property (wr && PADDR == 8'h20 |=>
      CALIB_OFFSET_EN == $past(PWDATA[1])) else $error("offset enable");
  AST_IRQ_HOLD:
    assert property (!HOST_INTERRUPT_N && !(wr && PADDR == 8'h24 &&
      PWDATA[16]) |=> !HOST_INTERRUPT_N) else $error("interrupt dropped");
  AST_NOISE:
    assert property (stb0 && LEVEL_CH0 < 8'h20 |-> ##3
      DIG_GAIN_CH0 <= $past(DIG_GAIN_CH0, 3)) else $error("gate rose");
  AST_ABOVE:
    assert property (stb0 && LEVEL_CH0 > 8'hE0 |-> ##3
      DIG_GAIN_CH0 <= $past(DIG_GAIN_CH0, 3)) else $error("loud rose");
  AST_WINDOW:
    assert property (stb0 && LEVEL_CH0 inside {[8'hC0:8'hE0]} |-> ##2
      DIG_GAIN_CH0 == $past(DIG_GAIN_CH0, 2))
      else $error("gain moved in window");
  AST_RE_TOTAL:
    assert property ($changed(ANA_GAIN_CH1) |-> {ANA_GAIN_CH1, 3'h0} +
      DIG_GAIN_CH1 == $past({ANA_GAIN_CH1, 3'h0} + DIG_GAIN_CH1))
      else $error("total gain moved");
  COV_LOUD: cover property (stb0 && LEVEL_CH0 > 8'hE0);
  COV_CAL: cover property ($fell(CALIB_ACTIVE));
  COV_IRQ: cover property ($fell(HOST_INTERRUPT_N));
endmodule
bind iglc_top iglc_chk u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSLVERR(PSLVERR), .SAMPLE_STB(SAMPLE_STB),
  .LEVEL_CH0(LEVEL_CH0), .DIG_GAIN_CH0(DIG_GAIN_CH0),
  .DIG_GAIN_CH1(DIG_GAIN_CH1), .ANA_GAIN_CH1(ANA_GAIN_CH1),
  .CALIB_ACTIVE(CALIB_ACTIVE), .CALIB_OFFSET_EN(CALIB_OFFSET_EN),
  .HOST_INTERRUPT_N(HOST_INTERRUPT_N));
`default_nettype wire

// >>> test/iglc_smp_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// sample strobe source, one pulse per PERIOD cycles
// ****
module iglc_smp_src #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,
  input  wire logic rstn,
  output var  logic stb
);
  int cnt_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 0;
      stb <= 1'b0;
    end else begin
      cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
      stb <= (cnt_ff == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

// >>> test/iglc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module iglc_top_tb;
  logic        clk, rstn, psel, pen, pwr;
  logic [7:0]  addr, g;
  logic [31:0] wdat;
  logic [7:0]  lvl [4];
  wire  [31:0] rdat;
  wire         stb, rdy, err, cal, ofs, irq_n;
  wire  [7:0]  dg [4];
  wire  [3:0]  ag [4];
  logic [31:0] exp_q [$];
  int          failures, compares, i;
  iglc_smp_src u_src (.clk(clk), .rstn(rstn), .stb(stb));
  iglc_top #(.RE_TIMEOUT_CYCLES(50)) u_dut (.CLK_SYS(clk), .RSTN(rstn),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(addr), .PWDATA(wdat),
    .PRDATA(rdat), .PREADY(rdy), .PSLVERR(err), .SAMPLE_STB(stb),
    .LEVEL_CH0(lvl[0]), .LEVEL_CH1(lvl[1]), .LEVEL_CH2(lvl[2]),
    .LEVEL_CH3(lvl[3]), .DIG_GAIN_CH0(dg[0]), .DIG_GAIN_CH1(dg[1]),
    .DIG_GAIN_CH2(dg[2]), .DIG_GAIN_CH3(dg[3]), .ANA_GAIN_CH0(ag[0]),
    .ANA_GAIN_CH1(ag[1]), .ANA_GAIN_CH2(ag[2]), .ANA_GAIN_CH3(ag[3]),
    .CALIB_ACTIVE(cal), .CALIB_OFFSET_EN(ofs), .HOST_INTERRUPT_N(irq_n));
  task automatic test_done;
    $display("checks %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // ****
  // apb master: d is write data, or the expected read data
  // ****
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    if (!w)
      exp_q.push_back(d);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= w ? d : 32'h0000_0000;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      failures++;
      test_done();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic smp(int k);
    repeat (k * 16 + 4) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic setl(int c, logic [7:0] v);
    @(posedge clk);
    lvl[c] <= v;
  endtask
  // read results are checked where the bus shows them
  always @(posedge clk) begin
    if (psel && pen && !pwr && rdy && exp_q.size() > 0)
      chk("prdata", exp_q.pop_front(), rdat);
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rstn, psel, pen, pwr, addr, wdat} = '0;
    lvl = '{default: 8'h00};
    failures = 0;
    compares = 0;
    void'($urandom(32'h8F1B));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 8'h04, 32'h0000_00F1);
    apb(1'b0, 8'h10, 32'h0000_F000);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    $display("reset values done");
    apb(1'b1, 8'h10, 32'h0000_F078);
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0001);
    setl(0, 8'hFF);
    setl(3, 8'hFF);
    smp(14);
    chk("ch0 floor", 8'h78, dg[0]);
    chk("ch3 idle", 8'h80, dg[3]);
    setl(3, 8'h00);
    g = $urandom;
    apb(1'b1, 8'h14, {8'h80, g, 16'h8080});
    smp(1);
    chk("ch0 manual", 8'h78, dg[0]);
    chk("ch2 manual", g, dg[2]);
    apb(1'b0, 8'h14, {8'h80, g, 16'h8080});
    setl(0, 8'hD0);
    smp(2);
    setl(0, 8'h30);
    smp(10);
    chk("hold", 8'h78, dg[0]);
    smp(12);
    chk("release", 1'b1, dg[0] > 8'h78);
    setl(0, 8'h10);
    smp(1);
    g = dg[0];
    smp(4);
    chk("gate", g, dg[0]);
    $display("level control done");
    apb(1'b1, 8'h10, 32'h0000_F040);
    apb(1'b1, 8'h04, 32'h0000_000F);
    apb(1'b1, 8'h00, 32'h0000_0021);
    setl(0, 8'hFF);
    smp(1);
    g = dg[0];
    smp(2);
    chk("anticlip", 1'b1, dg[0] + 8'h04 <= g);
    smp(20);
    apb(1'b1, 8'h14, {8'h80, g, 16'h8040});
    apb(1'b1, 8'h00, 32'h0000_0000);
    setl(0, 8'h00);
    apb(1'b1, 8'h1C, 32'h0000_06F2);
    smp(10);
    chk("re ana", 4'h6, ag[1]);
    chk("re dig", 8'h50, dg[1]);
    chk("re others", 8'h00, {ag[0], ag[2]});
    apb(1'b1, 8'h1C, 32'h0000_16F2);
    setl(1, 8'hFF);
    smp(2);
    chk("re clip", 4'h0, ag[1]);
    setl(1, 8'h00);
    $display("range extension done");
    // amplifier preparation is outside this block
    apb(1'b1, 8'h20, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0005);
    for (i = 0; i < 1100 && cal !== 1'b0; i++)
      @(posedge clk);
    chk("cal done", 1'b0, cal);
    if (cal !== 1'b0)
      test_done();
    apb(1'b1, 8'h20, 32'h0000_0002);
    smp(0);
    chk("offset", 1'b1, ofs);
    apb(1'b1, 8'h1C, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'h0032_F040);
    apb(1'b1, 8'h00, 32'h0000_0018);
    smp(0);
    chk("hyb ana", 4'h2, ag[3]);
    chk("hyb dig", 8'h70, dg[3]);
    apb(1'b0, 8'h28, {8'h70, g, 16'h8040});
    $display("calibration done");
    apb(1'b1, 8'h24, 32'h0000_0108);
    smp(1);
    chk("no irq", 1'b1, irq_n);
    setl(2, 8'hFF);
    smp(1);
    setl(2, 8'h00);
    smp(1);
    chk("irq", 1'b0, irq_n);
    apb(1'b0, 8'h24, 32'h0001_0108);
    apb(1'b1, 8'h24, 32'h0001_0108);
    smp(0);
    chk("irq clr", 1'b1, irq_n);
    $display("level detect done");
    test_done();
  end
endmodule
`default_nettype wire
